// >>> rtl/hdi2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module hdi2c_host #(
  parameter int HALF_CYC = hdi2c_pkg::HDI2C_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  hdi2c_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_dev,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_len,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic done
);
  typedef enum {HDI2C_H_IDLE, HDI2C_H_START, HDI2C_H_BIT, HDI2C_H_ACK, HDI2C_H_STOP}
    hdi2c_hst_t;
  typedef enum {HDI2C_P_ADDR, HDI2C_P_REG, HDI2C_P_WD, HDI2C_P_RADDR, HDI2C_P_RD} hdi2c_ph_t;
  hdi2c_hst_t st_q, st_d;
  hdi2c_ph_t ph_q, ph_d;
  logic [15:0] cnt_q, cnt_d;
  logic [1:0] q_q, q_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, left_q, left_d, rd_q, rd_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, nack_q, nack_d, rv_q, rv_d, dn_q, dn_d;
  logic sda_m_q, sda_s_q, tick;
  logic [15:0] half_c;
  assign half_c = 16'(HALF_CYC / 2);
  assign tick = (cnt_q == half_c);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= bus.sda_i;
      sda_s_q <= sda_m_q;
    end
  end
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
    q_d = q_q;
    bit_d = bit_q;
    sh_d = sh_q;
    left_d = left_q;
    rd_d = rd_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    nack_d = nack_q;
    rv_d = 1'b0;
    dn_d = 1'b0;
    if (st_q == HDI2C_H_IDLE) begin
      cnt_d = 16'h0000;
      q_d = 2'h0;
      if (cmd_valid) begin
        st_d = HDI2C_H_START;
        ph_d = HDI2C_P_ADDR;
        sh_d = {cmd_dev, 1'b0};
        left_d = cmd_len;
        nack_d = 1'b0;
      end
    end else if (tick) begin
      // quarter-period phases: 0 data, 1 scl high, 2 sample, 3 scl low edge
      q_d = q_q + 2'h1;
      case (st_q)
        HDI2C_H_START: begin
          // start: sda falls while scl high
          case (q_q)
            2'h0: begin
              scl_oe_d = 1'b0;
            end
            2'h1: begin
              sda_oe_d = 1'b0;
            end
            2'h2: begin
              sda_oe_d = 1'b1;
            end
            default: begin
              scl_oe_d = 1'b1;
              st_d = HDI2C_H_BIT;
              bit_d = 4'h0;
            end
          endcase
        end
        HDI2C_H_BIT, HDI2C_H_ACK: begin
          case (q_q)
            2'h0: begin
              // change sda only with scl low
              if (st_q == HDI2C_H_BIT) begin
                sda_oe_d = (ph_q == HDI2C_P_RD) ? 1'b0 : ~sh_q[7];
              end else begin
                // ack all but last read byte
                sda_oe_d = (ph_q == HDI2C_P_RD) && (left_q != 8'h01);
              end
            end
            2'h1: begin
              scl_oe_d = 1'b0;
            end
            2'h2: begin
              if (st_q == HDI2C_H_BIT) begin
                sh_d = {sh_q[6:0], sda_s_q};
                bit_d = bit_q + 4'h1;
              end else if (ph_q != HDI2C_P_RD && sda_s_q) begin
                nack_d = 1'b1;
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              if (st_q == HDI2C_H_BIT) begin
                if (bit_q == 4'(hdi2c_pkg::HDI2C_BYTE_BITS)) begin
                  st_d = HDI2C_H_ACK;
                  if (ph_q == HDI2C_P_RD) begin
                    rd_d = sh_q;
                    rv_d = 1'b1;
                  end
                end
              end else begin
                bit_d = 4'h0;
                st_d = HDI2C_H_BIT;
                // sda is left as it is until scl has fallen
                if (nack_q) begin
                  st_d = HDI2C_H_STOP;
                end else begin
                  case (ph_q)
                    HDI2C_P_ADDR: begin
                      ph_d = HDI2C_P_REG;
                      sh_d = cmd_reg;
                    end
                    HDI2C_P_REG: begin
                      if (cmd_read) begin
                        ph_d = HDI2C_P_RADDR;
                        sh_d = {cmd_dev, 1'b1};
                        st_d = HDI2C_H_START;
                      end else begin
                        ph_d = HDI2C_P_WD;
                        sh_d = cmd_wdata;
                      end
                    end
                    HDI2C_P_RADDR: begin
                      ph_d = HDI2C_P_RD;
                    end
                    default: begin
                      left_d = left_q - 8'h01;
                      sh_d = cmd_wdata;
                      if (left_q <= 8'h01) begin
                        st_d = HDI2C_H_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        HDI2C_H_STOP: begin
          case (q_q)
            2'h0: begin
              sda_oe_d = 1'b1;
            end
            2'h1: begin
              scl_oe_d = 1'b0;
            end
            2'h2: begin
              sda_oe_d = 1'b0;
            end
            default: begin
              st_d = HDI2C_H_IDLE;
              dn_d = 1'b1;
            end
          endcase
        end
        default: begin
          st_d = HDI2C_H_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= HDI2C_H_IDLE;
      ph_q <= HDI2C_P_ADDR;
      cnt_q <= 16'h0000;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      left_q <= 8'h00;
      rd_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nack_q <= 1'b0;
      rv_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      q_q <= q_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      left_q <= left_d;
      rd_q <= rd_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      nack_q <= nack_d;
      rv_q <= rv_d;
      dn_q <= dn_d;
    end
  end
  assign bus.scl_oe = scl_oe_q;
  assign bus.scl_o = 1'b0;
  assign bus.sda_host_oe = sda_oe_q;
  assign cmd_ready = (st_q == HDI2C_H_IDLE);
  assign rsp_valid = rv_q;
  assign rsp_data = rd_q;
  assign rsp_nack = nack_q;
  assign done = dn_q;
endmodule : hdi2c_host
`default_nettype wire

// >>> rtl/hdi2c_pkg.sv
// Notes on behaviour
// - bytes are eight bits, msb first
// - receiver acknowledges after the eighth bit
// - sda fall/rise with scl high: start/stop
// - data changes only while scl low
// - master sends 7-bit address plus direction
// - slave holds sda low whole ack
// - device answers only address 0x59
// - any byte count; master ends with stop
// - register address auto-increments until stop
// - write direction bit 0, then acknowledge
// - device acknowledges register-address byte
// - device acknowledges every written data byte
// - read starts with write of register address
// - master acks read bytes except last
// - lines only pulled low or released
// - single and multi-byte access every register
// - master waits for acknowledge each byte
package hdi2c_pkg;
  localparam logic [6:0] HDI2C_SLAVE_ADDR = 7'h59;
  localparam int HDI2C_CLK_HZ = 25000000;
  localparam int HDI2C_SCL_HZ = 100000;
  localparam int HDI2C_HALF_CYC = HDI2C_CLK_HZ / (2 * HDI2C_SCL_HZ);
  localparam int HDI2C_BYTE_BITS = 8;
endpackage : hdi2c_pkg

// >>> rtl/hdi2c_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hdi2c_if;
  logic scl_o;
  logic scl_oe;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic scl_i;
  logic sda_i;
  // wired-and: any enable pulls the line low
  assign scl_i = ~scl_oe;
  assign sda_i = ~(sda_dev_oe | sda_host_oe);
  modport dev (input scl_i, input sda_i, output sda_dev_oe);
  modport host (input scl_i, input sda_i, output scl_o, output scl_oe, output sda_host_oe);
endinterface : hdi2c_if
`default_nettype wire

// >>> rtl/hdi2c_dev.sv
`timescale 1ns/1ps
`default_nettype none
module hdi2c_dev (
  input wire logic ref_clk,
  input wire logic reset,
  hdi2c_if.dev bus,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rd_data
);
  typedef enum {HDI2C_D_IDLE, HDI2C_D_ADDR, HDI2C_D_REG, HDI2C_D_WR, HDI2C_D_RD,
    HDI2C_D_IGN} hdi2c_dst_t;
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  hdi2c_dst_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ra_q, ra_d, wd_q, wd_d;
  logic [3:0] bit_q, bit_d;
  logic ack_q, ack_d, oe_q, oe_d, wst_q, wst_d, rst_q, rst_d;
  logic scl_rise, scl_fall, start_c, stop_c;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3F;
    end else begin
      scl_m_q <= bus.scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= bus.sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    ra_d = ra_q;
    wd_d = wd_q;
    bit_d = bit_q;
    ack_d = ack_q;
    oe_d = oe_q;
    wst_d = 1'b0;
    rst_d = 1'b0;
    if (stop_c) begin
      st_d = HDI2C_D_IDLE;
      oe_d = 1'b0;
    end else if (start_c) begin
      st_d = HDI2C_D_ADDR;
      bit_d = 4'h0;
      ack_d = 1'b0;
      oe_d = 1'b0;
    end else if (scl_rise && !ack_q && st_q != HDI2C_D_IDLE && st_q != HDI2C_D_IGN) begin
      sh_d = {sh_q[6:0], sda_s_q};
      bit_d = bit_q + 4'h1;
    end else if (scl_rise && ack_q && st_q == HDI2C_D_RD) begin
      if (sda_s_q) begin
        st_d = HDI2C_D_IGN;
      end
    end else if (scl_fall && st_q != HDI2C_D_IDLE && st_q != HDI2C_D_IGN) begin
      if (ack_q) begin
        ack_d = 1'b0;
        bit_d = 4'h0;
        oe_d = 1'b0;
        if (st_q == HDI2C_D_RD) begin
          oe_d = ~rd_data[7];
          sh_d = rd_data;
          rst_d = 1'b1;
        end
      end else if (bit_q == 4'(hdi2c_pkg::HDI2C_BYTE_BITS)) begin
        ack_d = 1'b1;
        oe_d = 1'b0;
        case (st_q)
          HDI2C_D_ADDR: begin
            if (sh_q[7:1] == hdi2c_pkg::HDI2C_SLAVE_ADDR) begin
              oe_d = 1'b1;
              st_d = sh_q[0] ? HDI2C_D_RD : HDI2C_D_REG;
            end else begin
              st_d = HDI2C_D_IGN;
              ack_d = 1'b0;
            end
          end
          HDI2C_D_REG: begin
            ra_d = sh_q;
            oe_d = 1'b1;
            st_d = HDI2C_D_WR;
          end
          HDI2C_D_WR: begin
            wd_d = sh_q;
            wst_d = 1'b1;
            oe_d = 1'b1;
          end
          HDI2C_D_RD: begin
            ra_d = ra_q + 8'h01;
          end
          default: begin
            st_d = HDI2C_D_IGN;
          end
        endcase
      end else if (st_q == HDI2C_D_RD) begin
        // drive next bit on scl low
        oe_d = ~sh_q[7];
      end
    end
    if (wst_q) begin
      ra_d = ra_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= HDI2C_D_IDLE;
      sh_q <= 8'h00;
      ra_q <= 8'h00;
      wd_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      wst_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      ra_q <= ra_d;
      wd_q <= wd_d;
      bit_q <= bit_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      wst_q <= wst_d;
      rst_q <= rst_d;
    end
  end
  assign bus.sda_dev_oe = oe_q;
  assign reg_addr = ra_q;
  assign wr_data = wd_q;
  assign wr_stb = wst_q;
  assign rd_stb = rst_q;
endmodule : hdi2c_dev
`default_nettype wire

// >>> sim/hdi2c_props.sv
`timescale 1ns/1ps
`default_nettype none
module hdi2c_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  logic scl_q, sda_q, first_q, first_d, rd_q, rd_d, quiet_q, quiet_d, rise;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [4:0] hi_q, hi_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  assign rise = scl_i & ~scl_q;
  // bit position, direction and whether the device may drive
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    first_d = first_q;
    rd_d = rd_q;
    quiet_d = quiet_q;
    // cycles scl has been high, saturating
    hi_d = scl_i ? ((hi_q == 5'h1F) ? hi_q : hi_q + 5'h01) : 5'h00;
    if (rise) begin
      sh_d = {sh_q[6:0], sda_i};
      cnt_d = (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h7 && first_q) begin
        rd_d = sda_i;
        quiet_d = (sh_d[7:1] != hdi2c_pkg::HDI2C_SLAVE_ADDR);
      end
      if (cnt_q == 4'h8) begin
        first_d = 1'b0;
        if (rd_q && !first_q && sda_i) quiet_d = 1'b1;
      end
    end
    if (scl_i && scl_q && sda_q && !sda_i) begin
      cnt_d = 4'h0;
      first_d = 1'b1;
      rd_d = 1'b0;
      quiet_d = 1'b0;
    end
    if (scl_i && scl_q && !sda_q && sda_i) quiet_d = 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    scl_q <= reset ? 1'b1 : scl_i;
    sda_q <= reset ? 1'b1 : sda_i;
    cnt_q <= reset ? 4'h0 : cnt_d;
    sh_q <= reset ? 8'h00 : sh_d;
    first_q <= reset ? 1'b0 : first_d;
    rd_q <= reset ? 1'b0 : rd_d;
    quiet_q <= reset ? 1'b1 : quiet_d;
    hi_q <= reset ? 5'h00 : hi_d;
  end
  property p_scl_only_low; scl_o == 1'b0; endproperty
  a_scl_only_low: assert property (p_scl_only_low) else $error("scl driven high");
  property p_dev_change_low; $changed(sda_dev_oe) |-> !scl_i; endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("dev sda moved, scl high");
  property p_ack_held; rise && cnt_q == 4'h8 && !quiet_q && (first_q || !rd_q) |-> sda_dev_oe[*8]; endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack not held");
  property p_quiet; quiet_q |-> !sda_dev_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("dev drove sda while unselected");
  property p_host_stable; rise && cnt_q != 4'h0 |-> $stable(sda_host_oe)[*8]; endproperty
  a_host_stable: assert property (p_host_stable) else $error("host sda moved, scl high");
  property p_nack_release; rise && cnt_q == 4'h8 && rd_q && !first_q && sda_i |=> (!sda_dev_oe)[*8]; endproperty
  a_nack_release: assert property (p_nack_release) else $error("dev kept sda after nack");
  property p_scl_high_len;
    !scl_i && scl_q && cnt_q != 4'h0 |-> hi_q >= 5'h08 && hi_q <= 5'h14;
  endproperty
  a_scl_high_len: assert property (p_scl_high_len) else $error("scl high time wrong");
  property p_dev_silent; scl_i && !rise && cnt_q != 4'h0 && !rd_q |-> !sda_dev_oe; endproperty
  a_dev_silent: assert property (p_dev_silent) else $error("dev drove host bit");
endmodule : hdi2c_props
`default_nettype wire

// >>> sim/test_haptic_driver_i2c_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_haptic_driver_i2c_slave_port;
  localparam logic [6:0] ADR = hdi2c_pkg::HDI2C_SLAVE_ADDR;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_dev = 7'h00;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic cmd_ready, rsp_valid, rsp_nack, done, wr_stb, rd_stb;
  logic [7:0] rsp_data, reg_addr, wr_data, rd_data;
  logic [7:0] mem [256];
  logic [7:0] shadow [256];
  logic [15:0] wq [$];
  logic [7:0] rq [$];
  logic [7:0] raq [$];
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  hdi2c_if bus_if ();
  always #20 ref_clk = ~ref_clk;
  assign rd_data = mem[reg_addr];
  always @(posedge ref_clk) if (wr_stb === 1'b1) mem[reg_addr] <= wr_data;
  hdi2c_dev i_hdi2c_dev (.ref_clk(ref_clk), .reset(reset), .bus(bus_if.dev),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data));
  hdi2c_host #(.HALF_CYC(8)) i_hdi2c_host (.ref_clk(ref_clk), .reset(reset),
    .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_dev(cmd_dev),
    .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_len(cmd_len),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .done(done));
  hdi2c_props i_hdi2c_props (.ref_clk(ref_clk), .reset(reset), .scl_o(bus_if.scl_o),
    .scl_oe(bus_if.scl_oe), .sda_dev_oe(bus_if.sda_dev_oe),
    .sda_host_oe(bus_if.sda_host_oe), .scl_i(bus_if.scl_i), .sda_i(bus_if.sda_i));
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // notes the expected strobes and read bytes, then runs one command
  task automatic xfer(input logic [6:0] dev, input logic rd, input logic [7:0] rg,
      input logic [7:0] wd, input logic [7:0] len);
    int n;
    for (int k = 0; k < int'(len); k++) begin
      if (dev == ADR && rd) begin
        rq.push_back(shadow[rg + 8'(k)]);
        raq.push_back(rg + 8'(k));
      end
      if (dev == ADR && !rd) begin
        wq.push_back({rg + 8'(k), wd});
        shadow[rg + 8'(k)] = wd;
      end
    end
    @(negedge ref_clk);
    cmd_dev = dev;
    cmd_read = rd;
    cmd_reg = rg;
    cmd_wdata = wd;
    cmd_len = len;
    cmp("cmd_ready", 8'h01, {7'h00, cmd_ready});
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (done !== 1'b1) mismatches++;
    cmp("nack", {7'h00, dev != ADR}, {7'h00, rsp_nack});
    cmp("pending", 8'h00, 8'(wq.size() + rq.size() + raq.size()));
  endtask : xfer
  always @(negedge ref_clk) begin
    if (!reset && wr_stb === 1'b1) begin
      if (wq.size() == 0) cmp("wr_count", 8'h00, 8'h01);
      else begin
        cmp("wr_addr", wq[0][15:8], reg_addr);
        cmp("wr_data", wq[0][7:0], wr_data);
        void'(wq.pop_front());
      end
    end
    if (!reset && rsp_valid === 1'b1) begin
      if (rq.size() == 0) cmp("rd_count", 8'h00, 8'h01);
      else cmp("rd_data", rq.pop_front(), rsp_data);
    end
    if (!reset && rd_stb === 1'b1) begin
      if (raq.size() == 0) cmp("rd_stb_count", 8'h00, 8'h01);
      else cmp("rd_addr", raq.pop_front(), reg_addr);
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h942fb667));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      shadow[i] = mem[i];
    end
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    xfer(ADR, 1'b0, 8'h10, 8'hA5, 8'h03);
    xfer(ADR, 1'b1, 8'h10, 8'h00, 8'h03);
    xfer(ADR, 1'b0, 8'hFF, 8'h3C, 8'h01);
    xfer(ADR, 1'b1, 8'hFE, 8'h00, 8'h02);
    xfer(ADR ^ 7'h01, 1'b0, 8'h10, 8'h5A, 8'h02);
    xfer(ADR ^ 7'h40, 1'b1, 8'h10, 8'h00, 8'h01);
    xfer(ADR, 1'b1, 8'h10, 8'h00, 8'h01);
    for (int i = 0; i < 4; i++) begin
      xfer(ADR, 1'($urandom), 8'($urandom), 8'($urandom), 8'(1 + $urandom % 4));
    end
    summarize();
  end
endmodule : test_haptic_driver_i2c_slave_port
`default_nettype wire
